/* File: pkg/gfx_cfg_pkg.sv */
// Constants for the graphics configuration register bank
package gfx_cfg_pkg;
   // ==========================================================
   // Register offsets (dword-aligned configuration offsets)
   localparam logic [7:0] POWER_CTRL_OFFSET = 8'hd4;
   localparam logic [7:0] SW_EVENT_OFFSET = 8'he0;
   localparam logic [7:0] CLK_GATE_OFFSET = 8'hf0;
   // ==========================================================
   // Power-state field
   localparam int PS_LSB = 0;
   localparam int PS_MSB = 1;
   localparam int NO_INTERNAL_RESET_BIT = 3;
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D3 = 2'h3;
   localparam logic [1:0] PS_RESET = 2'h0;
   // ==========================================================
   // Software event register
   localparam int EVENT_SELECT_BIT = 15;
   localparam int SCRATCH_MSB = 14;
   localparam int SCRATCH_LSB = 1;
   localparam int SCI_TRIGGER_BIT = 0;
   localparam logic [15:0] SW_EVENT_RESET = 16'h0000;
   // ==========================================================
   // Clock gating control register
   localparam int CORE_CLOCK_GATE_BIT = 14;
   localparam logic [15:0] CLK_GATE_RESET = 16'h1606;
   localparam logic [15:0] CLK_GATE_WMASK = 16'h5f7f;
endpackage

/* File: pkg/sci_event_if.sv */
// Link between the register bank and the SCI message generator
`timescale 1ns/1ps
interface sci_event_if;
   logic select;
   logic trigger;
   logic msg;
   modport bank (output select, output trigger, input msg);
   modport gen (input select, input trigger, output msg);
endinterface

/* File: rtl/sci_message_gen.sv */
// Edge detector that turns a rising SCI trigger into one message pulse when select is set
`timescale 1ns/1ps
module sci_message_gen (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Asynchronous reset, active low
   sci_event_if.gen ev // Trigger in, message out
);
   logic trigger_prev;
   logic msg;
   wire rising = ev.trigger & ~trigger_prev;
   wire next_msg = ev.select & rising;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trigger_prev <= 1'b0;
         msg <= 1'b0;
      end else begin
         trigger_prev <= ev.trigger;
         msg <= next_msg;
      end
   end

   assign ev.msg = msg;

   // ==========================================================
   // Checks
   property p_sci_on_rise;
      @(posedge clk_i) disable iff (!rst_n_i)
      (ev.select && ev.trigger && !$past(ev.trigger)) |=> msg;
   endproperty
   a_sci_on_rise: assert property (p_sci_on_rise) else $error("rise lost");

   property p_sci_single;
      @(posedge clk_i) disable iff (!rst_n_i)
      msg |=> !msg;
   endproperty
   a_sci_single: assert property (p_sci_single) else $error("double message");

   property p_sci_cause;
      @(posedge clk_i) disable iff (!rst_n_i)
      msg |-> $past(ev.select) && $past(ev.trigger) && !$past(ev.trigger, 2);
   endproperty
   a_sci_cause: assert property (p_sci_cause) else $error("message without rise");
endmodule

/* File: rtl/gfx_cfg_regs.sv */
// Graphics configuration register bank: power state, SCI trigger, clock gate
`timescale 1ns/1ps
module gfx_cfg_regs
   import gfx_cfg_pkg::*;
(
   input wire logic SYS_CLK_I, // System clock, 50 MHz
   input wire logic RST_N_I, // Asynchronous reset, active low
   input wire logic CFG_WR_I, // Config write strobe
   input wire logic CFG_RD_I, // Config read strobe
   input wire logic [7:0] CFG_ADDR_I, // Dword-aligned config offset
   input wire logic [3:0] CFG_BE_I, // Byte enables
   input wire logic [31:0] CFG_WDATA_I, // Write data
   output logic [31:0] CFG_RDATA_O, // Read data
   output logic CFG_ACK_O, // Access complete
   output logic SCI_MSG_O, // SCI message pulse to hub
   output logic [1:0] POWER_STATE_O, // Current power state
   output logic CORE_CLOCK_GATE_O // 1 gates core display clock
);
   logic [1:0] power_state;
   logic [15:0] sw_event;
   logic [15:0] clk_gate;
   logic [31:0] rdata;
   logic ack;

   sci_event_if sci_link ();

   // ==========================================================
   // Address decode
   wire hit_power = (CFG_ADDR_I == POWER_CTRL_OFFSET);
   wire hit_event = (CFG_ADDR_I == SW_EVENT_OFFSET);
   wire hit_clk = (CFG_ADDR_I == CLK_GATE_OFFSET);
   wire [15:0] byte_mask = {{8{CFG_BE_I[1]}}, {8{CFG_BE_I[0]}}};
   wire [15:0] wdata_lo = CFG_WDATA_I[15:0];

   // ==========================================================
   // Power state
   wire [1:0] ps_wdata = CFG_WDATA_I[PS_MSB:PS_LSB];
   wire ps_supported = (ps_wdata == PS_D0) || (ps_wdata == PS_D3);
   wire ps_wr = CFG_WR_I & hit_power & CFG_BE_I[0] & ps_supported;
   // No internal reset on D3 to D0; other registers keep their values
   wire [1:0] next_power_state = ps_wr ? ps_wdata : power_state;

   // ==========================================================
   // Software event and clock gating
   wire ev_wr = CFG_WR_I & hit_event;
   wire [15:0] next_sw_event = ev_wr ? ((sw_event & ~byte_mask) | (wdata_lo & byte_mask))
                                     : sw_event;
   wire clk_wr = CFG_WR_I & hit_clk;
   wire [15:0] clk_wmask = byte_mask & CLK_GATE_WMASK;
   wire [15:0] next_clk_gate = clk_wr ? ((clk_gate & ~clk_wmask) | (wdata_lo & clk_wmask))
                                      : clk_gate;

   // ==========================================================
   // Read mux
   wire [15:0] power_rd = 16'h0000 | (16'h0001 << NO_INTERNAL_RESET_BIT)
                          | {14'h0000, power_state};
   wire [15:0] rd_lo = hit_power ? power_rd :
                       hit_event ? sw_event :
                       hit_clk ? clk_gate : 16'h0000;
   wire [31:0] next_rdata = CFG_RD_I ? {16'h0000, rd_lo} : rdata;
   wire next_ack = CFG_RD_I | CFG_WR_I;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         power_state <= PS_RESET;
         sw_event <= SW_EVENT_RESET;
         clk_gate <= CLK_GATE_RESET;
         rdata <= 32'h00000000;
         ack <= 1'b0;
      end else begin
         power_state <= next_power_state;
         sw_event <= next_sw_event;
         clk_gate <= next_clk_gate;
         rdata <= next_rdata;
         ack <= next_ack;
      end
   end

   // ==========================================================
   // SCI message generation
   assign sci_link.select = sw_event[EVENT_SELECT_BIT];
   assign sci_link.trigger = sw_event[SCI_TRIGGER_BIT];

   sci_message_gen u_sci_gen (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .ev(sci_link.gen)
   );

   assign CFG_RDATA_O = rdata;
   assign CFG_ACK_O = ack;
   assign SCI_MSG_O = sci_link.msg;
   assign POWER_STATE_O = power_state;
   assign CORE_CLOCK_GATE_O = clk_gate[CORE_CLOCK_GATE_BIT];

   // ==========================================================
   // Checks
   property p_ps_legal;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (POWER_STATE_O == PS_D0) || (POWER_STATE_O == PS_D3);
   endproperty
   a_ps_legal: assert property (p_ps_legal) else $error("illegal power state");

   property p_ps_write;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_WR_I && hit_power && CFG_BE_I[0] && ps_supported) |=> POWER_STATE_O == $past(ps_wdata);
   endproperty
   a_ps_write: assert property (p_ps_write) else $error("power write lost");

   property p_ps_unsupported;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_WR_I && hit_power && !ps_supported) |=> $stable(POWER_STATE_O) && CFG_ACK_O;
   endproperty
   a_ps_unsupported: assert property (p_ps_unsupported) else $error("D1/D2 taken");

   property p_no_soft_reset;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ($past(power_state) == PS_D3 && power_state == PS_D0)
         |-> $stable(clk_gate) && $stable(sw_event);
   endproperty
   a_no_soft_reset: assert property (p_no_soft_reset) else $error("context lost");

   property p_trigger_hold;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (sw_event[SCI_TRIGGER_BIT] && !ev_wr) |=> sw_event[SCI_TRIGGER_BIT];
   endproperty
   a_trigger_hold: assert property (p_trigger_hold) else $error("trigger self-cleared");

   property p_scratch_quiet;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (ev_wr && CFG_BE_I[0] && wdata_lo[SCI_TRIGGER_BIT] == sw_event[SCI_TRIGGER_BIT])
         |=> ##1 !SCI_MSG_O;
   endproperty
   a_scratch_quiet: assert property (p_scratch_quiet) else $error("scratch caused SCI");

   property p_gate_write;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (clk_wr && CFG_BE_I[1]) |=> CORE_CLOCK_GATE_O == $past(CFG_WDATA_I[CORE_CLOCK_GATE_BIT]);
   endproperty
   a_gate_write: assert property (p_gate_write) else $error("gate write lost");

   property p_reserved_ro;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (clk_gate & ~CLK_GATE_WMASK) == 16'h0000;
   endproperty
   a_reserved_ro: assert property (p_reserved_ro) else $error("read-only bit set");

   property p_event_read;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_RD_I && hit_event) |=> CFG_ACK_O && CFG_RDATA_O == {16'h0000, $past(sw_event)};
   endproperty
   a_event_read: assert property (p_event_read) else $error("event read wrong");

   property p_ack_follows;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_RD_I || CFG_WR_I) |=> CFG_ACK_O;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("access not acked");

   property p_ack_idle;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !(CFG_RD_I || CFG_WR_I) |=> !CFG_ACK_O;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack without access");

   property p_power_read;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_RD_I && hit_power) |=> CFG_RDATA_O[NO_INTERNAL_RESET_BIT]
         && CFG_RDATA_O[PS_MSB:PS_LSB] == $past(POWER_STATE_O);
   endproperty
   a_power_read: assert property (p_power_read) else $error("power read wrong");

   property p_clk_read;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_RD_I && hit_clk) |=> CFG_RDATA_O == {16'h0000, $past(clk_gate)};
   endproperty
   a_clk_read: assert property (p_clk_read) else $error("clock read wrong");

   property p_unmapped_read;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (CFG_RD_I && !hit_power && !hit_event && !hit_clk) |=> CFG_RDATA_O == 32'h00000000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not 0");

   property p_event_low;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (ev_wr && CFG_BE_I[0]) |=> sw_event[7:0] == $past(CFG_WDATA_I[7:0]);
   endproperty
   a_event_low: assert property (p_event_low) else $error("event low lane lost");

   property p_event_high;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (ev_wr && CFG_BE_I[1]) |=> sw_event[15:8] == $past(CFG_WDATA_I[15:8]);
   endproperty
   a_event_high: assert property (p_event_high) else $error("event high lane lost");

   // Hardware never alters the event register on its own
   property p_event_keep;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !ev_wr |=> $stable(sw_event);
   endproperty
   a_event_keep: assert property (p_event_keep) else $error("event register moved");

   property p_clock_keep;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !clk_wr |=> $stable(clk_gate);
   endproperty
   a_clock_keep: assert property (p_clock_keep) else $error("clock register moved");

   property p_power_keep;
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !(CFG_WR_I && hit_power) |=> $stable(POWER_STATE_O);
   endproperty
   a_power_keep: assert property (p_power_keep) else $error("power state moved");
endmodule

/* File: testbench/hub_event_model.sv */
// Hub side model that latches and counts SCI messages
`timescale 1ns/1ps
module hub_event_model (
   input wire logic clk_i, // System clock
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire logic sci_msg_i, // SCI message pulse
   output int msg_count_o, // Messages seen
   output logic hub_tco_sci_status_o // Set by a message
);
   // ==========================================================
   // Message capture
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         msg_count_o <= 0;
         hub_tco_sci_status_o <= 1'b0;
      end else if (sci_msg_i === 1'b1) begin
         msg_count_o <= msg_count_o + 1;
         hub_tco_sci_status_o <= 1'b1;
      end
   end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the graphics configuration register bank
`timescale 1ns/1ps
module tb_top;
   import gfx_cfg_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, ack, sci, gate, sts;
   logic [7:0] addr = 8'h00;
   logic [3:0] be = 4'h3;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [1:0] ps;
   int msgs, m0, bad_count = 0, checks = 0;
   gfx_cfg_regs dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(wr), .CFG_RD_I(rd),
      .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata),
      .CFG_ACK_O(ack), .SCI_MSG_O(sci), .POWER_STATE_O(ps), .CORE_CLOCK_GATE_O(gate));
   hub_event_model hub (.clk_i(clk), .rst_n_i(rst_n), .sci_msg_i(sci), .msg_count_o(msgs),
      .hub_tco_sci_status_o(sts));
   initial begin
      forever #10 clk = ~clk;
   end
   // ==========================================================
   // Shared tasks
   task results;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task cfg(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #1 wr = w;
      rd = !w;
      addr = a;
      wdata = {16'hffff, d};
      @(posedge clk);
      #1 wr = 0;
      rd = 0;
      while (ack !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1 n++;
      end
      if (ack !== 1'b1) begin
         bad_count++;
         results();
      end
      q = rdata;
   endtask
   task wr_sci(input logic [15:0] d, input int extra);
      cfg(1, SW_EVENT_OFFSET, d);
      repeat (2) @(posedge clk);
      #1 chk(32'(msgs), 32'(m0 + extra));
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      chk({30'h0, ps}, {30'h0, PS_RESET});
      chk({31'h0, gate}, 32'h0);
      cfg(0, SW_EVENT_OFFSET, 16'h0);
      chk(q, {16'h0, SW_EVENT_RESET});
      cfg(0, CLK_GATE_OFFSET, 16'h0);
      chk(q, {16'h0, CLK_GATE_RESET});
      cfg(0, POWER_CTRL_OFFSET, 16'h0);
      chk(q, 32'h8);
   endtask
   task t_power;
      cfg(1, CLK_GATE_OFFSET, 16'h0a5a);
      cfg(1, POWER_CTRL_OFFSET, 16'h3);
      chk({30'h0, ps}, {30'h0, PS_D3});
      for (int v = 1; v < 3; v++) begin
         cfg(1, POWER_CTRL_OFFSET, 16'(v));
         chk({30'h0, ps}, {30'h0, PS_D3});
      end
      cfg(1, POWER_CTRL_OFFSET, 16'h0);
      chk({30'h0, ps}, {30'h0, PS_D0});
      cfg(0, CLK_GATE_OFFSET, 16'h0);
      chk(q, 32'h0a5a);
   endtask
   task t_clock;
      cfg(1, CLK_GATE_OFFSET, 16'hffff);
      chk({31'h0, gate}, 32'h1);
      cfg(0, CLK_GATE_OFFSET, 16'h0);
      chk(q, {16'h0, CLK_GATE_WMASK});
      cfg(1, CLK_GATE_OFFSET, 16'h0);
      chk({31'h0, gate}, 32'h0);
   endtask
   task t_sci;
      m0 = msgs;
      wr_sci(16'h0001, 0);
      wr_sci(16'h8001, 0);
      wr_sci(16'h8000, 0);
      wr_sci(16'h8001, 1);
      chk({31'h0, sts}, 32'h1);
      wr_sci(16'hffff, 1);
      cfg(0, SW_EVENT_OFFSET, 16'h0);
      chk(q, 32'hffff);
      wr_sci(16'h0000, 1);
   endtask
   task t_unmapped;
      cfg(1, 8'h80, 16'hffff);
      cfg(0, 8'h80, 16'h0);
      chk(q, 32'h0);
   endtask
   task t_lanes;
      be = 4'h1;
      cfg(1, SW_EVENT_OFFSET, 16'h7e02);
      be = 4'h2;
      cfg(1, SW_EVENT_OFFSET, 16'h7c00);
      cfg(1, POWER_CTRL_OFFSET, 16'h0003);
      be = 4'h1;
      cfg(1, CLK_GATE_OFFSET, 16'h4000);
      be = 4'h3;
      chk({30'h0, ps}, {30'h0, PS_D0});
      chk({31'h0, gate}, 32'h0);
      cfg(0, SW_EVENT_OFFSET, 16'h0);
      chk(q, 32'h7c02);
   endtask
   task t_rerun;
      cfg(1, POWER_CTRL_OFFSET, 16'h3);
      cfg(1, CLK_GATE_OFFSET, 16'h4000);
      cfg(1, SW_EVENT_OFFSET, 16'h8000);
      rst_n = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      chk({30'h0, ps}, {30'h0, PS_RESET});
      chk({31'h0, gate}, 32'h0);
      chk({31'h0, sci}, 32'h0);
      cfg(0, SW_EVENT_OFFSET, 16'h0);
      chk(q, {16'h0, SW_EVENT_RESET});
      cfg(0, CLK_GATE_OFFSET, 16'h0);
      chk(q, {16'h0, CLK_GATE_RESET});
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      t_reset();
      t_power();
      t_clock();
      t_sci();
      t_lanes();
      t_unmapped();
      t_rerun();
      results();
   end
endmodule
